// ### hw/mmu_pkg.sv
// constants, register map and types for the address translation front end
// assumes a 25 MHz core clock and an AXI4-Lite master for configuration
package mmu_pkg;

    // translation buffer geometry
    localparam int TLB_ENTRIES = 8;
    localparam int IDX_W       = 3;

    // address widths
    localparam int VA_W        = 64;
    localparam int PA_W        = 36;
    localparam int PA_NARROW_W = 32;
    localparam int NARROW_VA_W = 32;
    localparam int USEG_TOP    = 40;
    localparam int TAG_W       = 8;
    localparam int PGN_W       = 28;
    localparam int PFN_W       = 24;
    localparam int ATTR_W      = 3;
    localparam int OFS_SMALL   = 12;
    localparam int OFS_LARGE   = 24;

    // privilege field encodings
    localparam logic [1:0] PRIV_KERN = 2'h0;
    localparam logic [1:0] PRIV_SUP  = 2'h1;
    localparam logic [1:0] PRIV_USER = 2'h2;

    // register byte offsets
    localparam int         BUS_AW        = 8;
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_ENTRY_HI = 8'h04;
    localparam logic [7:0] ADDR_TLB_PGN  = 8'h08;
    localparam logic [7:0] ADDR_TLB_PFN  = 8'h0C;
    localparam logic [7:0] ADDR_TLB_CMD  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_FAULT_LO = 8'h1C;
    localparam logic [7:0] ADDR_FAULT_HI = 8'h20;
    localparam logic [7:0] ADDR_MODE     = 8'h24;

    // control register fields
    localparam int CTRL_PRIV_LSB = 0;
    localparam int CTRL_EXC_LVL  = 2;
    localparam int CTRL_ERR_LVL  = 3;
    localparam int CTRL_U_WIDE   = 4;
    localparam int CTRL_S_WIDE   = 5;
    localparam int CTRL_K_WIDE   = 6;
    localparam int CTRL_BUS_WIDE = 7;
    localparam int CTRL_W        = 8;

    // staged entry fields
    localparam int PGNR_LARGE  = 28;
    localparam int PGNR_GLOBAL = 29;
    localparam int PGNR_VALID  = 30;
    localparam int PFNR_ATTR   = 24;

    // interrupt bits
    localparam int IRQ_MISS     = 0;
    localparam int IRQ_ADDR_ERR = 1;
    localparam int IRQ_W        = 2;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [TAG_W-1:0]  TAG_RESET  = 8'h00;
    localparam logic [31:0]       WORD_RESET = 32'h0000_0000;
    localparam logic [IRQ_W-1:0]  IRQ_RESET  = 2'h0;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_USER = 3'b001,
        MODE_SUP  = 3'b010,
        MODE_KERN = 3'b100
    } mode_t;

endpackage

// ### hw/tlb_entry_match.sv
// compare of one translation buffer entry against the current page number
// assumes the page number is already narrowed to the active address width
`timescale 1ns/10ps
module tlb_entry_match
    import mmu_pkg::*;
(
    // stored entry
    input  wire logic              entry_valid,
    input  wire logic              entry_large,
    input  wire logic              entry_global,
    input  wire logic [PGN_W-1:0]  entry_pgn,
    input  wire logic [TAG_W-1:0]  entry_tag,
    // current reference
    input  wire logic [PGN_W-1:0]  addr_pgn,
    input  wire logic [TAG_W-1:0]  cur_tag,
    // result
    output logic                   hit
);

    logic pgn_eq;
    logic tag_ok;

    // large pages ignore the low page-number bits, which sit in the offset
    always_comb begin
        if (entry_large) begin
            pgn_eq = entry_pgn[PGN_W-1:OFS_LARGE-OFS_SMALL] == addr_pgn[PGN_W-1:OFS_LARGE-OFS_SMALL];
        end else begin
            pgn_eq = entry_pgn == addr_pgn;
        end
        tag_ok = entry_global || (entry_tag == cur_tag);
        hit    = entry_valid && pgn_eq && tag_ok;
    end

endmodule

// ### hw/mmu_address_translation.sv
// user segment address check and translation buffer lookup with AXI4-Lite setup
// assumes one request per cycle from the pipeline and a single core clock
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module mmu_address_translation
    import mmu_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // write address, data and response channels
    input  wire logic [BUS_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // read channels
    input  wire logic [BUS_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // pipeline request
    input  wire logic              req_valid,
    input  wire logic [VA_W-1:0]   req_vaddr,
    // translated result
    output logic                   rsp_valid_q,
    output logic [PA_W-1:0]        rsp_paddr_q,
    output logic [ATTR_W-1:0]      rsp_attr_q,
    output logic                   rsp_miss_q,
    output logic                   rsp_addr_err_q,
    output logic                   rsp_other_seg_q,
    output logic                   rsp_wide_refill_q,
    // interrupt
    output logic                   irq_q
);

    // bus state
    logic              aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [BUS_AW-1:0] aw_addr_q;
    logic [31:0]       w_data_q, rdata_q;
    logic [3:0]        w_strb_q;
    logic [1:0]        bresp_q, rresp_q;
    logic              aw_take, w_take, wr_fire, ar_take;
    logic [31:0]       wmask;

    // configuration and staged entry
    logic [CTRL_W-1:0] ctrl_q;
    logic [TAG_W-1:0]  tag_q;
    logic [31:0]       stage_pgn_q, stage_pfn_q;
    logic [IDX_W-1:0]  last_idx_q;
    logic [IRQ_W-1:0]  irq_stat_q, irq_mask_q, irq_set, irq_clr;
    logic [VA_W-1:0]   fault_q;

    // translation buffer storage
    logic              ent_valid_q  [TLB_ENTRIES];
    logic              ent_large_q  [TLB_ENTRIES];
    logic              ent_global_q [TLB_ENTRIES];
    logic [PGN_W-1:0]  ent_pgn_q    [TLB_ENTRIES];
    logic [TAG_W-1:0]  ent_tag_q    [TLB_ENTRIES];
    logic [PFN_W-1:0]  ent_pfn_q    [TLB_ENTRIES];
    logic [ATTR_W-1:0] ent_attr_q   [TLB_ENTRIES];
    logic [TLB_ENTRIES-1:0] hit_vec;

    // translation datapath
    mode_t             mode;
    logic              wide_addr, sext_ok, in_useg, addr_err, lookup_en, other_seg, hit_any, miss;
    logic [IDX_W-1:0]  hit_idx;
    logic [PGN_W-1:0]  addr_pgn;
    logic [PA_W-1:0]   paddr_full;

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // address and data are held separately so either may arrive first
    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take  = s_axi_wvalid && wready_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    function automatic logic is_mapped(input logic [BUS_AW-1:0] a);
        is_mapped = (a == ADDR_CTRL) || (a == ADDR_ENTRY_HI) || (a == ADDR_TLB_PGN) || (a == ADDR_TLB_PFN)
                 || (a == ADDR_TLB_CMD) || (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK) || (a == ADDR_FAULT_LO)
                 || (a == ADDR_FAULT_HI) || (a == ADDR_MODE);
    endfunction

    // write channel handshake
    always_ff @(posedge clk) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q  <= WORD_RESET;
            w_strb_q  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            aw_held_q <= (aw_held_q || aw_take) && !wr_fire;
            w_held_q  <= (w_held_q || w_take) && !wr_fire;
            awready_q <= !((aw_held_q || aw_take) && !wr_fire);
            wready_q  <= !((w_held_q || w_take) && !wr_fire);
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // configuration registers; a write of the command register commits the staged entry
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_q      <= CTRL_RESET;
            tag_q       <= TAG_RESET;
            stage_pgn_q <= WORD_RESET;
            stage_pfn_q <= WORD_RESET;
            irq_mask_q  <= IRQ_RESET;
        end else if (wr_fire) begin
            unique case (aw_addr_q)
                ADDR_CTRL:     ctrl_q      <= (ctrl_q & ~wmask[CTRL_W-1:0]) | (w_data_q[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
                ADDR_ENTRY_HI: tag_q       <= (tag_q & ~wmask[TAG_W-1:0]) | (w_data_q[TAG_W-1:0] & wmask[TAG_W-1:0]);
                ADDR_TLB_PGN:  stage_pgn_q <= (stage_pgn_q & ~wmask) | (w_data_q & wmask);
                ADDR_TLB_PFN:  stage_pfn_q <= (stage_pfn_q & ~wmask) | (w_data_q & wmask);
                ADDR_IRQ_MASK: irq_mask_q  <= (irq_mask_q & ~wmask[IRQ_W-1:0]) | (w_data_q[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
                default: ;
            endcase
        end
    end

    // entry write takes the current space tag, so software sets the tag first
    always_ff @(posedge clk) begin
        if (!rstn) begin
            last_idx_q <= '0;
            for (int i = 0; i < TLB_ENTRIES; i++) begin
                ent_valid_q[i]  <= 1'b0;
                ent_large_q[i]  <= 1'b0;
                ent_global_q[i] <= 1'b0;
                ent_pgn_q[i]    <= '0;
                ent_tag_q[i]    <= '0;
                ent_pfn_q[i]    <= '0;
                ent_attr_q[i]   <= '0;
            end
        end else if (wr_fire && (aw_addr_q == ADDR_TLB_CMD) && w_strb_q[0]) begin
            last_idx_q                      <= w_data_q[IDX_W-1:0];
            ent_valid_q[w_data_q[IDX_W-1:0]]  <= stage_pgn_q[PGNR_VALID];
            ent_large_q[w_data_q[IDX_W-1:0]]  <= stage_pgn_q[PGNR_LARGE];
            ent_global_q[w_data_q[IDX_W-1:0]] <= stage_pgn_q[PGNR_GLOBAL];
            ent_pgn_q[w_data_q[IDX_W-1:0]]    <= stage_pgn_q[PGN_W-1:0];
            ent_tag_q[w_data_q[IDX_W-1:0]]    <= tag_q;
            ent_pfn_q[w_data_q[IDX_W-1:0]]    <= stage_pfn_q[PFN_W-1:0];
            ent_attr_q[w_data_q[IDX_W-1:0]]   <= stage_pfn_q[PFNR_ATTR+ATTR_W-1:PFNR_ATTR];
        end
    end

    // read channel; data is captured at the address handshake
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b0;
            rdata_q   <= WORD_RESET;
            rresp_q   <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q  <= 1'b1;
            arready_q <= 1'b0;
            rresp_q   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                ADDR_CTRL:     rdata_q <= {24'h000000, ctrl_q};
                ADDR_ENTRY_HI: rdata_q <= {24'h000000, tag_q};
                ADDR_TLB_PGN:  rdata_q <= stage_pgn_q;
                ADDR_TLB_PFN:  rdata_q <= stage_pfn_q;
                ADDR_TLB_CMD:  rdata_q <= {29'h00000000, last_idx_q};
                ADDR_IRQ_STAT: rdata_q <= {30'h00000000, irq_stat_q};
                ADDR_IRQ_MASK: rdata_q <= {30'h00000000, irq_mask_q};
                ADDR_FAULT_LO: rdata_q <= fault_q[31:0];
                ADDR_FAULT_HI: rdata_q <= fault_q[63:32];
                ADDR_MODE:     rdata_q <= {28'h0000000, wide_addr, mode};
                default:       rdata_q <= WORD_RESET;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end
    assign ar_take = s_axi_arvalid && arready_q;

    // privilege decode; the undefined field value 11 falls to kernel, the safe side
    always_comb begin
        if (ctrl_q[CTRL_EXC_LVL] || ctrl_q[CTRL_ERR_LVL] || (ctrl_q[CTRL_PRIV_LSB+1:CTRL_PRIV_LSB] == PRIV_KERN)) begin
            mode = MODE_KERN;
        end else if (ctrl_q[CTRL_PRIV_LSB+1:CTRL_PRIV_LSB] == PRIV_USER) begin
            mode = MODE_USER;
        end else if (ctrl_q[CTRL_PRIV_LSB+1:CTRL_PRIV_LSB] == PRIV_SUP) begin
            mode = MODE_SUP;
        end else begin
            mode = MODE_KERN;
        end
        unique case (mode)
            MODE_USER: wide_addr = ctrl_q[CTRL_U_WIDE];
            MODE_SUP:  wide_addr = ctrl_q[CTRL_S_WIDE];
            MODE_KERN: wide_addr = ctrl_q[CTRL_K_WIDE];
        endcase
    end

    // legality and segment check ahead of the lookup
    always_comb begin
        sext_ok = req_vaddr[VA_W-1:NARROW_VA_W] == {(VA_W-NARROW_VA_W){req_vaddr[NARROW_VA_W-1]}};
        if (wide_addr) begin
            in_useg  = req_vaddr[VA_W-1:USEG_TOP] == '0;
            addr_err = (mode == MODE_USER) && !in_useg;
            addr_pgn = req_vaddr[USEG_TOP-1:OFS_SMALL];
        end else begin
            in_useg  = !req_vaddr[NARROW_VA_W-1];
            addr_err = !sext_ok || ((mode == MODE_USER) && req_vaddr[NARROW_VA_W-1]);
            addr_pgn = {8'h00, req_vaddr[NARROW_VA_W-1:OFS_SMALL]};
        end
        // segments other than the user one are handed on untranslated
        other_seg = !addr_err && !in_useg;
        lookup_en = !addr_err && in_useg;
    end

    // one comparator per entry
    generate
        for (genvar g = 0; g < TLB_ENTRIES; g++) begin : g_match
            tlb_entry_match u_match (
                .entry_valid  (ent_valid_q[g]),
                .entry_large  (ent_large_q[g]),
                .entry_global (ent_global_q[g]),
                .entry_pgn    (ent_pgn_q[g]),
                .entry_tag    (ent_tag_q[g]),
                .addr_pgn     (addr_pgn),
                .cur_tag      (tag_q),
                .hit          (hit_vec[g])
            );
        end
    endgenerate

    // lowest index wins if software left duplicate entries behind
    always_comb begin
        hit_any = 1'b0;
        hit_idx = '0;
        for (int i = TLB_ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                hit_any = 1'b1;
                hit_idx = IDX_W'(i);
            end
        end
        miss = lookup_en && !hit_any;
        if (ent_large_q[hit_idx]) begin
            paddr_full = {ent_pfn_q[hit_idx][PFN_W-1:OFS_LARGE-OFS_SMALL], req_vaddr[OFS_LARGE-1:0]};
        end else begin
            paddr_full = {ent_pfn_q[hit_idx], req_vaddr[OFS_SMALL-1:0]};
        end
        if (!ctrl_q[CTRL_BUS_WIDE]) begin
            paddr_full[PA_W-1:PA_NARROW_W] = '0;
        end
    end

    // result register, one cycle behind the request
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rsp_valid_q       <= 1'b0;
            rsp_paddr_q       <= '0;
            rsp_attr_q        <= '0;
            rsp_miss_q        <= 1'b0;
            rsp_addr_err_q    <= 1'b0;
            rsp_other_seg_q   <= 1'b0;
            rsp_wide_refill_q <= 1'b0;
        end else begin
            rsp_valid_q <= req_valid;
            if (req_valid) begin
                rsp_paddr_q       <= (lookup_en && hit_any) ? paddr_full : '0;
                rsp_attr_q        <= (lookup_en && hit_any) ? ent_attr_q[hit_idx] : '0;
                rsp_miss_q        <= miss;
                rsp_addr_err_q    <= addr_err;
                rsp_other_seg_q   <= other_seg;
                rsp_wide_refill_q <= wide_addr;
            end
        end
    end

    // sticky status; a new event beats a same-cycle clear
    assign irq_set = req_valid ? {addr_err, miss} : 2'h0;
    assign irq_clr = (wr_fire && (aw_addr_q == ADDR_IRQ_STAT)) ? (w_data_q[IRQ_W-1:0] & wmask[IRQ_W-1:0]) : 2'h0;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_stat_q <= IRQ_RESET;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            irq_q      <= |(irq_stat_q & irq_mask_q);
        end
    end

    // faulting address for the refill handler
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fault_q <= '0;
        end else if (req_valid && (addr_err || miss)) begin
            fault_q <= req_vaddr;
        end
    end

    user_bit31_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && mode == MODE_USER && !wide_addr && req_vaddr[31] |=> rsp_addr_err_q && !rsp_miss_q)
        else $error("narrow user reference above 2G not refused");
    wide_user_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && mode == MODE_USER && wide_addr && (req_vaddr[63:40] != '0) |=> rsp_addr_err_q)
        else $error("wide user reference above 1T not refused");
    sign_ext_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && !wide_addr && (req_vaddr[63:32] != {32{req_vaddr[31]}}) |=> rsp_addr_err_q)
        else $error("bad sign extension not refused");
    err_no_miss_a: assert property (@(posedge clk) disable iff (!rstn)
        rsp_addr_err_q |-> !rsp_miss_q && rsp_paddr_q == '0)
        else $error("address error also looked up");
    narrow_pa_a: assert property (@(posedge clk) disable iff (!rstn)
        rsp_valid_q && !$past(ctrl_q[CTRL_BUS_WIDE]) |-> rsp_paddr_q[35:32] == 4'h0)
        else $error("narrow bus address exceeds 32 bits");
    offset_pass_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && lookup_en && hit_any |=> rsp_paddr_q[11:0] == $past(req_vaddr[11:0]) && !rsp_miss_q)
        else $error("page offset altered");
    refill_sel_a: assert property (@(posedge clk) disable iff (!rstn)
        req_valid && mode == MODE_USER |=> rsp_wide_refill_q == $past(ctrl_q[CTRL_U_WIDE]))
        else $error("user refill vector wrong");
    user_mode_a: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_q[1:0] == 2'h2 && !ctrl_q[CTRL_EXC_LVL] && !ctrl_q[CTRL_ERR_LVL] |-> mode == MODE_USER)
        else $error("user mode not decoded");
    kern_mode_a: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_q[1:0] == 2'h0 || ctrl_q[CTRL_EXC_LVL] || ctrl_q[CTRL_ERR_LVL] |-> mode == MODE_KERN)
        else $error("kernel mode not decoded");
    miss_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        rsp_valid_q && rsp_miss_q |-> irq_stat_q[IRQ_MISS] ##1 (irq_q || !$past(irq_mask_q[IRQ_MISS])))
        else $error("miss not flagged");

endmodule

// ### test/pipe_model.sv
// pipeline stand-in issuing one virtual address lookup per call
// assumes the core clock of the translation block; drives after rising edges
`timescale 1ns/10ps
module pipe_model
    import mmu_pkg::*;
(
    // clock
    input  wire logic       clk,
    // request toward the block
    output logic            req_valid,
    output logic [VA_W-1:0] req_vaddr
);
    // idle at time zero
    initial begin
        req_valid = 1'b0;
        req_vaddr = '0;
    end
    // one request for one edge; idle address is inverted so a stale value never looks current
    task automatic issue(input logic [VA_W-1:0] va);
        @(posedge clk);
        req_valid <= 1'b1;
        req_vaddr <= va;
        @(posedge clk);
        req_valid <= 1'b0;
        req_vaddr <= ~va;
    endtask
endmodule

// ### test/mmu_address_translation_test.sv
// bench for the translation front end: AXI4-Lite setup plus lookups
// assumes the pipeline model and one 25 MHz clock
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module mmu_address_translation_test
    import mmu_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0;
    logic [BUS_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_q, rsp_valid_q;
    logic rsp_miss_q, rsp_addr_err_q, rsp_other_seg_q, rsp_wide_refill_q, req_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [VA_W-1:0] req_vaddr;
    logic [PA_W-1:0] rsp_paddr_q;
    logic [ATTR_W-1:0] rsp_attr_q;
    int n_mismatch = 0, total_checks = 0, cycles = 0;

    always #20 clk = ~clk;

    pipe_model pipe (.clk(clk), .req_valid(req_valid), .req_vaddr(req_vaddr));
    mmu_address_translation uut (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .req_valid(req_valid), .req_vaddr(req_vaddr),
        .rsp_valid_q(rsp_valid_q), .rsp_paddr_q(rsp_paddr_q), .rsp_attr_q(rsp_attr_q),
        .rsp_miss_q(rsp_miss_q), .rsp_addr_err_q(rsp_addr_err_q), .rsp_other_seg_q(rsp_other_seg_q),
        .rsp_wide_refill_q(rsp_wide_refill_q), .irq_q(irq_q));

    // verdict and end of run, also reached from the hang guard
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 4000) begin
            n_mismatch++;
            complete_run;
        end
    end

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
            if (s_axi_wvalid && s_axi_wready) begin dd = 1'b1; s_axi_wvalid <= 1'b0; end
        end
        while (!s_axi_bvalid) @(posedge clk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // read: rready held until the data edge
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // one lookup; fields sampled the cycle after the request
    task automatic look(input logic [VA_W-1:0] va, input logic er, input logic ms, input logic [PA_W-1:0] pa);
        pipe.issue(va);
        @(posedge clk);
        `CHK("rsp_valid", 1'b1, rsp_valid_q)
        `CHK("addr_err", er, rsp_addr_err_q)
        `CHK("miss", ms, rsp_miss_q)
        `CHK("paddr", pa, rsp_paddr_q)
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdr(ADDR_MODE);
        `CHK("mode", 32'h0000_0004, rd)
        look(64'h0000_0001_0000_0000, 1'b1, 1'b0, 36'h0_0000_0000);
        $display("test reset done");
        wr(ADDR_CTRL, 32'h0000_0002);
        rdr(ADDR_MODE);
        `CHK("mode", 32'h0000_0001, rd)
        look(64'hFFFF_FFFF_8000_0000, 1'b1, 1'b0, 36'h0_0000_0000);
        look(64'h0000_0000_1234_5678, 1'b0, 1'b1, 36'h0_0000_0000);
        `CHK("refill", 1'b0, rsp_wide_refill_q)
        $display("test user narrow done");
        wr(ADDR_ENTRY_HI, 32'h0000_005A);
        wr(ADDR_TLB_PGN, 32'h4001_2345);
        wr(ADDR_TLB_PFN, 32'h03FA_BCDE);
        wr(ADDR_TLB_CMD, 32'h0000_0002);
        look(64'h0000_0000_1234_5678, 1'b0, 1'b0, 36'h0_ABCD_E678);
        `CHK("attr", 3'h3, rsp_attr_q)
        wr(ADDR_ENTRY_HI, 32'h0000_0011);
        look(64'h0000_0000_1234_5678, 1'b0, 1'b1, 36'h0_0000_0000);
        wr(ADDR_ENTRY_HI, 32'h0000_005A);
        wr(ADDR_CTRL, 32'h0000_0081);
        look(64'h0000_0000_1234_5678, 1'b0, 1'b0, 36'hF_ABCD_E678);
        $display("test translate done");
        wr(ADDR_CTRL, 32'h0000_0092);
        look(64'h0000_0100_0000_0000, 1'b1, 1'b0, 36'h0_0000_0000);
        `CHK("refill", 1'b1, rsp_wide_refill_q)
        look(64'h0000_0000_1234_5678, 1'b0, 1'b0, 36'hF_ABCD_E678);
        $display("test user wide done");
        wr(ADDR_CTRL, 32'h0000_0040);
        `CHK("bresp", RESP_OKAY, rs)
        rdr(ADDR_MODE);
        `CHK("mode", 32'h0000_000C, rd)
        look(64'h4000_0000_0000_0000, 1'b0, 1'b0, 36'h0_0000_0000);
        `CHK("other_seg", 1'b1, rsp_other_seg_q)
        look(64'h0000_0000_1234_5678, 1'b0, 1'b0, 36'h0_ABCD_E678);
        `CHK("other_seg", 1'b0, rsp_other_seg_q)
        $display("test kernel wide done");
        rdr(ADDR_FAULT_HI);
        `CHK("fault_hi", 32'h0000_0100, rd)
        rdr(ADDR_IRQ_STAT);
        `CHK("irq_stat", 32'h0000_0003, rd)
        wr(ADDR_IRQ_MASK, 32'h0000_0003);
        @(posedge clk);
        `CHK("irq", 1'b1, irq_q)
        wr(ADDR_IRQ_STAT, 32'h0000_0003);
        @(posedge clk);
        `CHK("irq", 1'b0, irq_q)
        wr(8'h40, 32'h0000_0001);
        `CHK("bresp", RESP_SLVERR, rs)
        rdr(8'h40);
        `CHK("rresp", RESP_SLVERR, rs)
        $display("test irq and bus done");
        complete_run;
    end
endmodule
